// >>> rsr_defines.svh
// register offsets, field positions and reset values of the state and status slice
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH
`define RSR_OFS_CONTROL_EXIT 6'h0a
`define RSR_OFS_CONTROL_FAULT 6'h0b
`define RSR_OFS_STATE_CTRL 6'h0c
`define RSR_OFS_FAULT_STAT 6'h0d
`define RSR_OFS_PIN_MON 6'h0e
`define RSR_BIT_DIAGNOSTIC_STATE_EXIT 0
`define RSR_BIT_UV_KEEP 0
`define RSR_BIT_DIAGNOSTIC_STATE_ENTRY 2
`define RSR_BIT_LOOP_EN 1
`define RSR_BIT_EXC_EN 0
`define RSR_RESET_WORD 16'h0000
`define RSR_CTRL_MASK 16'h0003
`define RSR_PIN_MASK 16'h7fff
`define RSR_SIF_OK 2'h0
`define RSR_SIF_CRC 2'h1
`define RSR_SIF_MISMATCH 2'h2
`define RSR_SIF_ADDR 2'h3
`endif

// >>> rsr_pkg.sv
// types shared by the state and status slice
package rsr_pkg;
   typedef enum logic [2:0] {
      RSR_ST_RESET = 3'h1,
      RSR_ST_NORMAL = 3'h2,
      RSR_ST_DIAGNOSTIC_STATE = 3'h4
   } rsr_state_type;
   typedef struct packed {
      logic loopClamp;
      logic configCrc;
      logic userNvmCrc;
      logic trimNvmCrc;
      logic excCurrentLimit;
      logic excUnderVoltage;
      logic excOverVoltage;
      logic loopError;
      logic cosLowOpen;
      logic sinLowOpen;
      logic cosHighOpen;
      logic sinHighOpen;
      logic groundOpen;
      logic inputShort;
   } rsr_fault_type;
   typedef struct packed {
      logic crcOrClock;
      logic mismatch;
      logic badAddress;
   } rsr_sif_type;
endpackage

// >>> rsr_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module rsr_sync #(
   parameter int WIDTH = 15
) (
   input wire logic clk_sys, // core clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [WIDTH-1:0] asyncIn, // pin levels
   output logic [WIDTH-1:0] syncOut // levels on clk_sys
);
   logic [WIDTH-1:0] stageOne;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stageOne <= '0;
         syncOut <= '0;
      end else begin
         stageOne <= asyncIn;
         syncOut <= stageOne;
      end
   end
endmodule

// >>> rsr_sticky_flag.sv
// clear-on-read flags, one per bit, set winning over the read
`timescale 1ns/100ps
module rsr_sticky_flag #(
   parameter int WIDTH = 14
) (
   input wire logic clk_sys, // core clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [WIDTH-1:0] setIn, // fault condition levels
   input wire logic readClear, // register read pulse
   output logic [WIDTH-1:0] flag // held flags
);
   logic [WIDTH-1:0] next_flag;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         // still-present condition re-sets in the clearing cycle
         assign next_flag[i] = setIn[i] | (flag[i] & ~readClear);
      end
   endgenerate
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         flag <= '0;
      end else begin
         flag <= next_flag;
      end
   end
endmodule

// >>> rsr_state_status.sv
// state request, exciter and loop enables, fault and pin-monitor registers
//
// How it works
// [RULE1] writing diagnostic_state entry bit moves normal state to diagnostic state
// [RULE2] diagnostic_state entry bit self-clears and always reads zero
// [RULE3] loop and exciter enables set on first normal entry after reset
// [RULE4] host may write both enables in diagnostic or normal state
// [RULE5] loop enable cleared when a fault disables the exciter
// [RULE6] exciter enable cleared and held low while unmasked fault active
// [RULE7] both status registers and state control reset to zero
// [RULE8] status flags of fault register clear on read
// [RULE9] bit 15 flags tracking loop clamp
// [RULE10] bit 14 flags configuration register crc error
// [RULE11] bit 13 flags user nonvolatile memory crc error
// [RULE12] bit 12 flags trim nonvolatile memory crc error
// [RULE13] bits 11..9 current limit, undervoltage, overvoltage of exciter
// [RULE14] bit 8 flags tracking loop error
// [RULE15] bits 7..4 cos-low, sin-low, cos-high, sin-high open faults
// [RULE16] serial status 00 no error, 01 crc or clock error
// [RULE17] serial status 10 on data output mismatch
// [RULE18] serial status 11 on invalid address
// [RULE19] bit 1 ground open, bit 0 input short
// [RULE20] pin monitor bit 14 mirrors ready pin
// [RULE21] pin monitor bits 13..0 mirror angle pins
// [RULE22] diagnostic_state exit bit moves diagnostic to normal, self-clears, reads zero
// [RULE23] undervoltage disables exciter unless keep-enabled control is set
// [RULE24] clear-on-read flag holds until read, re-sets if fault persists
// [RULE25] reserved bits read zero and ignore writes
`timescale 1ns/100ps
`include "rsr_defines.svh"
module rsr_state_status
   import rsr_pkg::*;
(
   input wire logic clk_sys, // core clock, 20 MHz
   input wire logic rst_n, // synchronous power-on reset, active low
   input wire logic regWrite, // register write strobe, one cycle
   input wire logic regRead, // register read strobe, one cycle
   input wire logic [5:0] regAddr, // register offset
   input wire logic [15:0] regWdata, // write data
   input wire rsr_fault_type faultIn, // fault detector levels, core clock
   input wire logic excFaultMasked, // exciter faults other than uv, masked
   input wire rsr_sif_type sifErr, // previous frame error pulses
   input wire logic parallel_ready_out, // ready pin level
   input wire logic [13:0] parallel_angle_out, // angle pin levels
   output logic [15:0] regRdata, // read data, registered
   output logic regRvalid, // read data valid pulse
   output logic tracking_loop_enable, // loop enable control
   output logic exciter_enable, // exciter enable control
   output logic diagnostic_state // device in diagnostic state
);
   // =================================================================
   // pin synchronisers and flags
   logic [14:0] pinSync;
   rsr_sync #(.WIDTH(15)) u_pins (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .asyncIn({parallel_ready_out, parallel_angle_out}),
      .syncOut(pinSync)
   );

   logic readFault;
   logic [13:0] flag;
   assign readFault = regRead && (regAddr == `RSR_OFS_FAULT_STAT);
   rsr_sticky_flag #(.WIDTH(14)) u_flags (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .setIn(faultIn), // [RULE8] [RULE24]
      .readClear(readFault),
      .flag(flag)
   );

   // =================================================================
   // serial interface status, last error of previous frame
   logic [1:0] sifStat;
   logic [1:0] next_sifStat;
   always_comb begin
      next_sifStat = readFault ? `RSR_SIF_OK : sifStat; // [RULE16]
      if (sifErr.crcOrClock) begin
         next_sifStat = `RSR_SIF_CRC; // [RULE16]
      end
      if (sifErr.mismatch) begin
         next_sifStat = `RSR_SIF_MISMATCH; // [RULE17]
      end
      if (sifErr.badAddress) begin
         next_sifStat = `RSR_SIF_ADDR; // [RULE18]
      end
   end

   // =================================================================
   // state machine and enables
   rsr_state_type state;
   rsr_state_type next_state;
   logic uvKeep;
   logic next_uvKeep;
   logic excKill;
   logic wrState;
   logic wrExit;
   logic wrFault;
   logic next_loop;
   logic next_exc;
   logic next_diagnostic_state;
   assign wrState = regWrite && (regAddr == `RSR_OFS_STATE_CTRL);
   assign wrExit = regWrite && (regAddr == `RSR_OFS_CONTROL_EXIT);
   assign wrFault = regWrite && (regAddr == `RSR_OFS_CONTROL_FAULT);
   // live fault levels, not flags, so the kill lasts only while active
   assign excKill = excFaultMasked
      | (faultIn.excUnderVoltage & ~uvKeep); // [RULE23]

   always_comb begin
      next_state = state;
      next_loop = tracking_loop_enable;
      next_exc = exciter_enable;
      next_uvKeep = wrFault ? regWdata[`RSR_BIT_UV_KEEP] : uvKeep;
      if (wrState) begin
         next_loop = regWdata[`RSR_BIT_LOOP_EN]; // [RULE4]
         next_exc = regWdata[`RSR_BIT_EXC_EN]; // [RULE4]
      end
      case (state)
         RSR_ST_RESET: begin
            next_state = RSR_ST_NORMAL;
            next_loop = 1'b1; // [RULE3]
            next_exc = 1'b1; // [RULE3]
         end
         RSR_ST_NORMAL: begin
            if (wrState && regWdata[`RSR_BIT_DIAGNOSTIC_STATE_ENTRY]) begin
               next_state = RSR_ST_DIAGNOSTIC_STATE; // [RULE1]
            end
         end
         RSR_ST_DIAGNOSTIC_STATE: begin
            if (wrExit && regWdata[`RSR_BIT_DIAGNOSTIC_STATE_EXIT]) begin
               next_state = RSR_ST_NORMAL; // [RULE22]
            end
         end
         default: begin
            next_state = RSR_ST_RESET;
         end
      endcase
      // fault overrides both host write and power-on set
      if (excKill) begin
         next_exc = 1'b0; // [RULE6]
         next_loop = 1'b0; // [RULE5]
      end
      next_diagnostic_state = (next_state == RSR_ST_DIAGNOSTIC_STATE);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= RSR_ST_RESET;
         tracking_loop_enable <= 1'b0; // [RULE7]
         exciter_enable <= 1'b0; // [RULE7]
         diagnostic_state <= 1'b0;
         uvKeep <= 1'b0;
         sifStat <= `RSR_SIF_OK; // [RULE7]
      end else begin
         state <= next_state;
         tracking_loop_enable <= next_loop;
         exciter_enable <= next_exc;
         diagnostic_state <= next_diagnostic_state;
         uvKeep <= next_uvKeep;
         sifStat <= next_sifStat;
      end
   end

   // =================================================================
   // read path, registered one cycle after the strobe
   logic [15:0] readWord;
   logic [15:0] next_rdata;
   logic next_rvalid;
   always_comb begin
      case (regAddr)
         `RSR_OFS_STATE_CTRL: begin
            // entry request never stored, reads zero
            readWord = {14'h0000, tracking_loop_enable,
               exciter_enable} & `RSR_CTRL_MASK; // [RULE2] [RULE25]
         end
         `RSR_OFS_CONTROL_FAULT: begin
            readWord = {15'h0000, uvKeep};
         end
         `RSR_OFS_FAULT_STAT: begin
            readWord = {flag[13:6], // [RULE9] [RULE10] [RULE11]
               // [RULE12] [RULE13] [RULE14] [RULE15]
               flag[5:2], sifStat, flag[1:0]}; // [RULE16] [RULE19]
         end
         `RSR_OFS_PIN_MON: begin
            readWord = {1'b0, pinSync} & `RSR_PIN_MASK; // [RULE20] [RULE21]
         end
         default: begin
            readWord = `RSR_RESET_WORD; // exit bit and unmapped read zero
         end
      endcase
      next_rdata = regRead ? readWord : regRdata;
      next_rvalid = regRead;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         regRdata <= `RSR_RESET_WORD;
         regRvalid <= 1'b0;
      end else begin
         regRdata <= next_rdata;
         regRvalid <= next_rvalid;
      end
   end

   // =================================================================
   // assertions
   a_diagnostic_state_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == RSR_ST_NORMAL && wrState && regWdata[2])
      |=> ##1 diagnostic_state) // [RULE1]
      else $error("diagnostic_state entry did not reach diagnostic state");
   a_entry_reads_zero: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (regRead && regAddr == `RSR_OFS_STATE_CTRL) |=> !regRdata[2])
      // [RULE2]
      else $error("diagnostic_state entry bit read back nonzero");
   a_exc_fault_hold: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      excKill |=> !exciter_enable && !tracking_loop_enable) // [RULE6]
      else $error("enable not cleared under exciter fault");
   a_uv_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (uvKeep && faultIn.excUnderVoltage && !excFaultMasked && !wrState
       && exciter_enable) |=> exciter_enable) // [RULE23]
      else $error("uv disabled exciter despite keep control");
   a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (flag[13] && !readFault) |=> flag[13]) // [RULE24]
      else $error("clamp flag lost without a read");
   a_flag_reset_on_read: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (readFault && !faultIn.loopClamp) |=> !flag[13]) // [RULE8]
      else $error("clamp flag not cleared by read");
   a_sif_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sifErr.badAddress |=> sifStat == `RSR_SIF_ADDR) // [RULE18]
      else $error("address error not encoded as 11");
   a_pin_mirror: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (regRead && regAddr == `RSR_OFS_PIN_MON)
      |=> regRdata == {1'b0, $past(pinSync)}) // [RULE21]
      else $error("pin monitor does not mirror pins");
   a_diagnostic_state_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state == RSR_ST_DIAGNOSTIC_STATE && wrExit && regWdata[0])
      |=> ##1 !diagnostic_state) // [RULE22]
      else $error("diagnostic_state exit did not return to normal");
   a_auto_enable: assert property (@(posedge clk_sys) // [RULE3]
      disable iff (!rst_n)
      (state == RSR_ST_RESET && !excKill)
      |=> tracking_loop_enable && exciter_enable)
      else $error("enables not set on first normal entry");
   a_host_loop_wr: assert property (@(posedge clk_sys) // [RULE4]
      disable iff (!rst_n)
      (wrState && state != RSR_ST_RESET && !excKill)
      |=> tracking_loop_enable == $past(regWdata[1]))
      else $error("host write to loop enable lost");
   a_host_exc_wr: assert property (@(posedge clk_sys) // [RULE4]
      disable iff (!rst_n)
      (wrState && state != RSR_ST_RESET && !excKill)
      |=> exciter_enable == $past(regWdata[0]))
      else $error("host write to exciter enable lost");
   a_loop_fault_clr: assert property (@(posedge clk_sys) // [RULE5]
      disable iff (!rst_n)
      excKill |=> !tracking_loop_enable)
      else $error("loop enable kept while exciter killed");
   a_reset_zero: assert property (@(posedge clk_sys) // [RULE7]
      !rst_n |=> (regRdata == 16'h0000 && !tracking_loop_enable
         && !exciter_enable && !diagnostic_state))
      else $error("outputs not zero after reset");
   a_clamp_bit: assert property (@(posedge clk_sys) // [RULE9]
      disable iff (!rst_n)
      (faultIn.loopClamp ##[1:3] readFault) |=> regRdata[15])
      else $error("clamp not reported in bit 15");
   a_cfg_crc_bit: assert property (@(posedge clk_sys) // [RULE10]
      disable iff (!rst_n)
      (faultIn.configCrc ##[1:3] readFault) |=> regRdata[14])
      else $error("config crc not reported in bit 14");
   a_user_crc_bit: assert property (@(posedge clk_sys) // [RULE11]
      disable iff (!rst_n)
      (faultIn.userNvmCrc ##[1:3] readFault) |=> regRdata[13])
      else $error("user memory crc not reported in bit 13");
   a_trim_crc_bit: assert property (@(posedge clk_sys) // [RULE12]
      disable iff (!rst_n)
      (faultIn.trimNvmCrc ##[1:3] readFault) |=> regRdata[12])
      else $error("trim memory crc not reported in bit 12");
   a_ilim_bit: assert property (@(posedge clk_sys) // [RULE13]
      disable iff (!rst_n)
      (faultIn.excCurrentLimit ##[1:3] readFault) |=> regRdata[11])
      else $error("current limit not reported in bit 11");
   a_loop_err_bit: assert property (@(posedge clk_sys) // [RULE14]
      disable iff (!rst_n)
      (faultIn.loopError ##[1:3] readFault) |=> regRdata[8])
      else $error("loop error not reported in bit 8");
   a_cos_low_bit: assert property (@(posedge clk_sys) // [RULE15]
      disable iff (!rst_n)
      (faultIn.cosLowOpen ##[1:3] readFault) |=> regRdata[7])
      else $error("cos low open not reported in bit 7");
   a_gnd_open_bit: assert property (@(posedge clk_sys) // [RULE19]
      disable iff (!rst_n)
      (faultIn.groundOpen ##[1:3] readFault) |=> regRdata[1])
      else $error("ground open not reported in bit 1");
   a_short_bit: assert property (@(posedge clk_sys) // [RULE19]
      disable iff (!rst_n)
      (faultIn.inputShort ##[1:3] readFault) |=> regRdata[0])
      else $error("input short not reported in bit 0");
   a_sif_crc: assert property (@(posedge clk_sys) // [RULE16]
      disable iff (!rst_n)
      (sifErr.crcOrClock && !sifErr.mismatch && !sifErr.badAddress)
      |=> sifStat == `RSR_SIF_CRC)
      else $error("crc or clock error not encoded as 01");
   a_sif_mismatch: assert property (@(posedge clk_sys) // [RULE17]
      disable iff (!rst_n)
      (sifErr.mismatch && !sifErr.badAddress) |=> sifStat == 2'h2)
      else $error("mismatch not encoded as 10");
   a_sif_clear: assert property (@(posedge clk_sys) // [RULE16]
      disable iff (!rst_n)
      (readFault && sifErr == 3'h0) |=> sifStat == 2'h0)
      else $error("serial status not cleared by read");
   a_ready_mirror: assert property (@(posedge clk_sys) // [RULE20]
      disable iff (!rst_n)
      (regRead && regAddr == `RSR_OFS_PIN_MON)
      |=> regRdata[15:14] == {1'b0, $past(pinSync[14])})
      else $error("ready pin not mirrored in bit 14");
   a_ctrl_reserved: assert property (@(posedge clk_sys) // [RULE25]
      disable iff (!rst_n)
      (regRead && regAddr == `RSR_OFS_STATE_CTRL) |=> regRdata[15:2] == 0)
      else $error("reserved control bits read nonzero");
   a_exit_reads_zero: assert property (@(posedge clk_sys) // [RULE22]
      disable iff (!rst_n)
      (regRead && regAddr == `RSR_OFS_CONTROL_EXIT) |=> regRdata == 0)
      else $error("diagnostic_state exit bit read back nonzero");
endmodule

// >>> rsr_host_model.sv
// host model issuing register writes and reads on the core clock
`timescale 1ns/100ps
module rsr_host_model (
   input wire logic clk_sys, // core clock
   input wire logic [15:0] regRdata, // read data
   input wire logic regRvalid, // read data valid
   output logic regWrite, // write strobe
   output logic regRead, // read strobe
   output logic [5:0] regAddr, // register offset
   output logic [15:0] regWdata // write data
);
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 6'h3f;
      regWdata = 16'h0000;
   end
   // released lines show the inverse so stale values never match by luck
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [15:0] d,
                     output logic v);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'b0;
      regAddr <= ~a;
      #1;
      v = regRvalid;
      d = regRdata;
   endtask
endmodule

// >>> rsr_state_status_bench.sv
// self-checking bench for the state and status register slice
`timescale 1ns/100ps
module rsr_state_status_bench
   import rsr_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   rsr_fault_type faultIn = '0;
   logic excFaultMasked = 1'b0;
   rsr_sif_type sifErr = '0;
   logic readyPin = 1'b0;
   logic [13:0] anglePins = 14'h0000;
   logic regWrite, regRead, regRvalid, loopEn, excEn, diagSt, rv;
   logic [5:0] regAddr;
   logic [15:0] regWdata, regRdata, rdv, e;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   always #25 clk_sys = ~clk_sys;
   rsr_host_model host_u (.clk_sys(clk_sys), .regRdata(regRdata),
      .regRvalid(regRvalid), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata));
   rsr_state_status dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWdata(regWdata), .faultIn(faultIn),
      .excFaultMasked(excFaultMasked), .sifErr(sifErr),
      .parallel_ready_out(readyPin), .parallel_angle_out(anglePins),
      .regRdata(regRdata), .regRvalid(regRvalid),
      .tracking_loop_enable(loopEn), .exciter_enable(excEn),
      .diagnostic_state(diagSt));
   // ==========================================
   // checking and closing
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk16(input logic [15:0] g, input logic [15:0] x);
      comparisons++;
      if (g !== x) begin
         n_fail++;
         $display("ERROR %0t word %h expected %h", $time, g, x);
      end
   endtask
   task automatic chk3(input logic [2:0] g, input logic [2:0] x);
      comparisons++;
      if (g !== x) begin
         n_fail++;
         $display("ERROR %0t loop/exc/diagnostic_state %b expected %b", $time, g, x);
      end
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [15:0] x);
      host_u.rd(a, rdv, rv);
      chk3({2'b00, rv}, 3'b001);
      chk16(rdv, x);
   endtask
   // state is checked two edges after the write strobe is taken
   task automatic st(input logic [2:0] x);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk3({loopEn, excEn, diagSt}, x);
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         $display("ERROR %0t timeout", $time);
         close_out();
      end
   end
   // ==========================================
   // tests
   initial begin
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      chk3({loopEn, excEn, diagSt}, 3'b000);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      st(3'b110);
      rdchk(6'h0c, 16'h0003);
      rdchk(6'h0d, 16'h0000);
      rdchk(6'h0e, 16'h0000);
      rdchk(6'h3f, 16'h0000);
      $display("test reset done");
      host_u.wr(6'h0c, 16'hffff);
      st(3'b111);
      rdchk(6'h0c, 16'h0003);
      host_u.wr(6'h0c, 16'h0000);
      st(3'b001);
      host_u.wr(6'h0c, 16'h0003);
      st(3'b111);
      host_u.wr(6'h0a, 16'h0001);
      st(3'b110);
      rdchk(6'h0a, 16'h0000);
      $display("test state done");
      @(posedge clk_sys);
      excFaultMasked <= 1'b1;
      st(3'b000);
      host_u.wr(6'h0c, 16'h0003);
      st(3'b000);
      excFaultMasked <= 1'b0;
      host_u.wr(6'h0c, 16'h0003);
      st(3'b110);
      host_u.wr(6'h0b, 16'h0000);
      faultIn.excUnderVoltage <= 1'b1;
      st(3'b000);
      faultIn <= '0;
      host_u.wr(6'h0c, 16'h0003);
      host_u.wr(6'h0b, 16'h0001);
      faultIn.excUnderVoltage <= 1'b1;
      st(3'b110);
      faultIn <= '0;
      rdchk(6'h0d, 16'h0400);
      rdchk(6'h0d, 16'h0000);
      $display("test exciter done");
      for (int i = 0; i < 14; i++) begin
         @(posedge clk_sys);
         faultIn <= rsr_fault_type'(14'h0001 << i);
         @(posedge clk_sys);
         faultIn <= '0;
         e = (i >= 2) ? (16'h0004 << i) : (16'h0001 << i);
         rdchk(6'h0d, e);
         rdchk(6'h0d, 16'h0000);
      end
      faultIn.inputShort <= 1'b1;
      rdchk(6'h0d, 16'h0001);
      rdchk(6'h0d, 16'h0001);
      faultIn <= '0;
      rdchk(6'h0d, 16'h0001);
      rdchk(6'h0d, 16'h0000);
      $display("test flags done");
      for (int k = 1; k < 5; k++) begin
         @(posedge clk_sys);
         sifErr <= (k == 4) ? 3'h7 : rsr_sif_type'(3'h1 << (3 - k));
         @(posedge clk_sys);
         sifErr <= '0;
         e = (k == 4) ? 16'h000c : 16'(k * 4);
         rdchk(6'h0d, e);
      end
      rdchk(6'h0d, 16'h0000);
      $display("test serial status done");
      readyPin <= 1'b1;
      anglePins <= 14'h2a5b;
      host_u.wr(6'h0e, 16'h0000);
      rdchk(6'h0e, 16'h6a5b);
      readyPin <= 1'b0;
      anglePins <= 14'h15a4;
      host_u.wr(6'h0e, 16'hffff);
      rdchk(6'h0e, 16'h15a4);
      $display("test pins done");
      close_out();
   end
endmodule
